// ===== hw/updown_counter_stage.sv
// Purpose : One reversible modulo-16 counter stage with preset, terminal flag
//           and ripple carry, driven from the link pins
// Assumes : countClock comes from another party and is sampled on clk;
//           gate and direction are stable around the detected rising edge
// Notes   : Preset is shown on the outputs combinationally and loaded into
//           the count register every clk cycle while held
//           A step lands four clk edges after the counting clock pin rises,
//           so each counting clock phase must last well beyond that
//           Gate and direction are read without sampling flops; the far
//           end changes them only while the counting clock is LOW
//           The terminal flag is a combinational decode; sample it as data
`timescale 1ns/100ps
`default_nettype none

module updown_counter_stage (
  input  wire logic                clk,
  input  wire logic                rst_n,
  counter_link_if.device           link,
  output var  logic                stepPulse,
  output var  logic                wrapPulse,
  output var  counter_pkg::mode_t  modeNow
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Mode from the three control pins, preset first
  // HOLD is only the start value; every branch overwrites it, so an unknown gate or direction pin falls through to UP or DOWN
  function automatic counter_pkg::mode_t decodeMode(
    input logic presetN,
    input logic gateN,
    input logic down
  );
    counter_pkg::mode_t m;
    m = counter_pkg::MODE_HOLD;
    if (!presetN) begin
      m = counter_pkg::MODE_PRESET;
    end else if (gateN) begin
      m = counter_pkg::MODE_HOLD;
    end else if (down) begin
      m = counter_pkg::MODE_DOWN;
    end else begin
      m = counter_pkg::MODE_UP;
    end
    return m;
  endfunction

  // Terminal decode of a count for a given direction
  // Shared by the wrap pulse and the flag so the two never disagree
  function automatic logic isTerminal(
    input logic [3:0] value,
    input logic       down
  );
    logic hit;
    hit = down ? (value == counter_pkg::COUNT_FLOOR)
               : (value == counter_pkg::COUNT_TOP);
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Counting clock sampling
  // ----------------------------------------------------------------
  // Three-flop chain on the pin and the level it has settled on
  logic [2:0] clkSyncReg;
  logic [2:0] clkSyncNext;
  logic       clkLevelReg;
  logic       clkLevelNext;
  logic       clkRise;

  // Shift the pin through three flops; a level counts once stages two and three agree
  // Level starts HIGH, the pin's idle level, so reset makes no false rise
  // A glitch shorter than one clk never reaches two agreeing stages
  always_comb begin
    clkSyncNext  = {clkSyncReg[1:0], link.countClock};
    clkLevelNext = clkLevelReg;
    clkRise      = 1'b0;
    if (clkSyncReg[1] == clkSyncReg[2]) begin
      clkLevelNext = clkSyncReg[2];
      clkRise      = clkSyncReg[2] & ~clkLevelReg;
    end
  end

  // Register the sampler
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkSyncReg  <= counter_pkg::SYNC_RESET;
      clkLevelReg <= 1'b1;
    end else begin
      clkSyncReg  <= clkSyncNext;
      clkLevelReg <= clkLevelNext;
    end
  end

  // ----------------------------------------------------------------
  // Count state
  // ----------------------------------------------------------------
  // Count register, event pulses, decoded mode and carry arming
  logic [3:0]          countReg;
  logic [3:0]          countNext;
  logic [3:0]          countShown;
  logic                stepReg;
  logic                stepNext;
  logic                wrapReg;
  logic                wrapNext;
  counter_pkg::mode_t  mode;
  logic                carryArmed;

  // Mode is decoded once and shared by steering and the user output
  assign mode = decodeMode(link.presetStrobeN, link.countGateN, link.dirDown);

  // Steering between preset, increment, decrement and hold
  // Preset reloads the register every clk while held, standing in for an
  // asynchronous load without an extra reset path into the flops
  always_comb begin
    countNext = countReg;
    stepNext  = 1'b0;
    wrapNext  = 1'b0;
    case (mode)
      counter_pkg::MODE_PRESET: begin
        countNext = link.presetInputs;
      end
      counter_pkg::MODE_UP: begin
        if (clkRise) begin
          countNext = countReg + counter_pkg::COUNT_STEP;
          stepNext  = 1'b1;
          wrapNext  = isTerminal(countReg, 1'b0);
        end
      end
      counter_pkg::MODE_DOWN: begin
        if (clkRise) begin
          countNext = countReg - counter_pkg::COUNT_STEP;
          stepNext  = 1'b1;
          wrapNext  = isTerminal(countReg, 1'b1);
        end
      end
      counter_pkg::MODE_HOLD: begin
        countNext = countReg;
      end
      default: begin
        countNext = countReg;
      end
    endcase
  end

  // Four state bits plus the event pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countReg <= counter_pkg::COUNT_RESET;
      stepReg  <= 1'b0;
      wrapReg  <= 1'b0;
    end else begin
      countReg <= countNext;
      stepReg  <= stepNext;
      wrapReg  <= wrapNext;
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------

  // Preset shows at once, without waiting for a clk edge
  assign countShown = link.presetStrobeN ? countReg : link.presetInputs;
  assign link.countValue = countShown;

  // Flag follows count and direction only, never the gate
  // It is decoded from the shown count, so a preset moves it at once
  assign link.terminalFlag = isTerminal(countShown, link.dirDown);

  // Carry is armed only while ungated, terminal and not presetting
  always_comb begin
    carryArmed = 1'b0;
    if (link.presetStrobeN && !link.countGateN && link.terminalFlag) begin
      carryArmed = 1'b1;
    end
  end

  // Carry pulses LOW through the sampled clock LOW phase; it returns HIGH
  // as soon as the sampled level rises, a few clk after the pin does
  assign link.stageCarryPulseN = ~(carryArmed & ~clkLevelReg);

  // ----------------------------------------------------------------
  // User side
  // ----------------------------------------------------------------
  // Pulses and mode for local logic; they are not part of the link
  assign stepPulse = stepReg;
  assign wrapPulse = wrapReg;
  assign modeNow   = mode;

endmodule

`default_nettype wire

// ===== pkg/counter_pkg.sv
// Purpose : Shared constants and types for the reversible 4-bit counter stage
// Assumes : Both ends run on one clk; the counting clock is a divided level
// Notes   : Every count, width and reset value used by more than one file lives here
`default_nettype none

package counter_pkg;

  // ----------------------------------------------------------------
  // Count layout
  // ----------------------------------------------------------------
  localparam int          COUNT_W     = 4;
  localparam logic [3:0]  COUNT_TOP   = 4'hf;   // Terminal value counting up
  localparam logic [3:0]  COUNT_FLOOR = 4'h0;   // Terminal value counting down
  localparam logic [3:0]  COUNT_STEP  = 4'h1;
  localparam logic [3:0]  COUNT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Input sampling and timing
  // ----------------------------------------------------------------
  localparam int          SYNC_STAGES     = 3;      // Flops on the counting clock pin
  localparam logic [2:0]  SYNC_RESET      = 3'h7;   // Counting clock idles HIGH
  localparam logic [7:0]  CLK_HALF_CYCLES = 8'h08;  // clk cycles per half counting clock
  localparam logic [7:0]  PRESET_CYCLES   = 8'h03;  // clk cycles the preset strobe is held

  // ----------------------------------------------------------------
  // Operating modes of one stage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOLD   = 2'b00,
    MODE_UP     = 2'b01,
    MODE_DOWN   = 2'b10,
    MODE_PRESET = 2'b11
  } mode_t;

  // Control-end sequencer states
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_LOAD = 2'b01
  } ctl_state_t;

endpackage

`default_nettype wire

// ===== pkg/counter_link_if.sv
// Purpose : Pins between one counter stage and its control logic
// Assumes : All pins are single-driver, no two-way pins
// Notes   : countClock is made by the control end from clk
`timescale 1ns/100ps
`default_nettype none

interface counter_link_if;

  logic       countClock;        // Counting clock, rising edge counts
  logic       presetStrobeN;     // Preset strobe, active low
  logic [3:0] presetInputs;      // Preset value
  logic       countGateN;        // Count gate, active low
  logic       dirDown;           // Direction, HIGH counts down
  logic [3:0] countValue;        // Count outputs
  logic       terminalFlag;      // Terminal count
  logic       stageCarryPulseN;  // Ripple carry, active low

  modport device (
    input  countClock, presetStrobeN, presetInputs, countGateN, dirDown,
    output countValue, terminalFlag, stageCarryPulseN
  );

  modport control (
    output countClock, presetStrobeN, presetInputs, countGateN, dirDown,
    input  countValue, terminalFlag, stageCarryPulseN
  );

endinterface

`default_nettype wire

// ===== hw/counter_control_end.sv
// Purpose : Control party of one counter stage: makes the counting clock,
//           drives preset, gate and direction, and watches the outputs
// Assumes : Same clk as the stage; stage outputs need no sampling flops
// Notes   : Gate and direction change only as the counting clock falls
`timescale 1ns/100ps
`default_nettype none

module counter_control_end (
  input  wire logic        clk,
  input  wire logic        rst_n,
  counter_link_if.control  link,
  input  wire logic        runEnable,
  input  wire logic        countDown,
  input  wire logic        loadRequest,
  input  wire logic [3:0]  loadValue,
  output var  logic        loadBusy,
  output var  logic [3:0]  countSeen,
  output var  logic        terminalSeen,
  output var  logic        carrySeen
);

  // ----------------------------------------------------------------
  // Counting clock divider
  // ----------------------------------------------------------------
  logic [7:0] divReg;
  logic [7:0] divNext;
  logic       cpReg;
  logic       cpNext;
  logic       gateNReg;
  logic       gateNNext;
  logic       downReg;
  logic       downNext;

  // Toggle every half period; controls follow on the falling edge for setup
  always_comb begin
    divNext   = divReg + 8'h01;
    cpNext    = cpReg;
    gateNNext = gateNReg;
    downNext  = downReg;
    if (divReg == counter_pkg::CLK_HALF_CYCLES - 8'h01) begin
      divNext = 8'h00;
      cpNext  = ~cpReg;
      if (cpReg) begin
        gateNNext = ~runEnable;
        downNext  = countDown;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divReg   <= 8'h00;
      cpReg    <= 1'b1;
      gateNReg <= 1'b1;
      downReg  <= 1'b0;
    end else begin
      divReg   <= divNext;
      cpReg    <= cpNext;
      gateNReg <= gateNNext;
      downReg  <= downNext;
    end
  end

  // ----------------------------------------------------------------
  // Preset sequencer
  // ----------------------------------------------------------------
  counter_pkg::ctl_state_t stateReg;
  counter_pkg::ctl_state_t stateNext;
  logic [7:0]              loadCntReg;
  logic [7:0]              loadCntNext;
  logic [3:0]              valueReg;
  logic [3:0]              valueNext;

  // Hold the strobe low for a fixed count with the value steady
  always_comb begin
    stateNext   = stateReg;
    loadCntNext = loadCntReg;
    valueNext   = valueReg;
    case (stateReg)
      counter_pkg::CTL_IDLE: begin
        if (loadRequest) begin
          stateNext   = counter_pkg::CTL_LOAD;
          loadCntNext = 8'h00;
          valueNext   = loadValue;
        end
      end
      counter_pkg::CTL_LOAD: begin
        loadCntNext = loadCntReg + 8'h01;
        if (loadCntReg == counter_pkg::PRESET_CYCLES - 8'h01) begin
          stateNext = counter_pkg::CTL_IDLE;
        end
      end
      default: begin
        stateNext = counter_pkg::CTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg   <= counter_pkg::CTL_IDLE;
      loadCntReg <= 8'h00;
      valueReg   <= counter_pkg::COUNT_RESET;
    end else begin
      stateReg   <= stateNext;
      loadCntReg <= loadCntNext;
      valueReg   <= valueNext;
    end
  end

  // ----------------------------------------------------------------
  // Observation of the stage, sampled as data, never as a clock
  // ----------------------------------------------------------------
  logic [3:0] countSeenReg;
  logic       termSeenReg;
  logic       carryPrevReg;
  logic       carrySeenReg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countSeenReg <= counter_pkg::COUNT_RESET;
      termSeenReg  <= 1'b0;
      carryPrevReg <= 1'b1;
      carrySeenReg <= 1'b0;
    end else begin
      countSeenReg <= link.countValue;
      termSeenReg  <= link.terminalFlag;
      carryPrevReg <= link.stageCarryPulseN;
      carrySeenReg <= carryPrevReg & ~link.stageCarryPulseN;
    end
  end

  // ----------------------------------------------------------------
  // Pin and user outputs
  // ----------------------------------------------------------------
  assign link.countClock    = cpReg;
  assign link.countGateN    = gateNReg;
  assign link.dirDown       = downReg;
  assign link.presetStrobeN = (stateReg != counter_pkg::CTL_LOAD);
  assign link.presetInputs  = valueReg;
  assign loadBusy           = (stateReg == counter_pkg::CTL_LOAD);
  assign countSeen          = countSeenReg;
  assign terminalSeen       = termSeenReg;
  assign carrySeen          = carrySeenReg;

endmodule

`default_nettype wire

// ===== bench/counter_link_asserts.sv
// Purpose : Concurrent checks on the pins between a counter stage and its control end
// Assumes : One clk; rst_n synchronous, active low
// Notes   : Step and carry windows allow for the three-flop sampler on the counting clock
`timescale 1ns/100ps
`default_nettype none

module counter_link_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       countClock,
  input wire logic       presetStrobeN,
  input wire logic [3:0] presetInputs,
  input wire logic       countGateN,
  input wire logic       dirDown,
  input wire logic [3:0] countValue,
  input wire logic       terminalFlag,
  input wire logic       stageCarryPulseN
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PRESET_BYPASS: assert property (!presetStrobeN |-> countValue == presetInputs)
    else $error("count outputs do not follow the preset value");
  AST_HOLD_GATED: assert property (
    countGateN && $past(countGateN, 4) && presetStrobeN && $past(presetStrobeN) |-> $stable(countValue))
    else $error("count moved while the gate was high");
  AST_STEP_UP: assert property (
    $rose(countClock) && !countGateN && !dirDown && presetStrobeN
      |-> ##[2:5] countValue == $past(countValue) + 4'h1)
    else $error("no up step after a counting clock rise");
  AST_STEP_DOWN: assert property (
    $rose(countClock) && !countGateN && dirDown && presetStrobeN
      |-> ##[2:5] countValue == $past(countValue) - 4'h1)
    else $error("no down step after a counting clock rise");
  AST_FLAG_DECODE: assert property (
    terminalFlag == ((!dirDown && countValue == 4'hf) || (dirDown && countValue == 4'h0)))
    else $error("terminal flag does not match count and direction");
  AST_CARRY_IDLE: assert property (
    countGateN || !terminalFlag || !presetStrobeN |-> stageCarryPulseN)
    else $error("carry low while gated, not terminal or presetting");
  AST_CARRY_LOW_PHASE: assert property (
    $fell(countClock) && !countGateN && terminalFlag && presetStrobeN |-> ##[1:5] !stageCarryPulseN)
    else $error("carry did not go low in the clock low phase");
  AST_CARRY_RETURN: assert property ($rose(countClock) |-> ##[1:5] stageCarryPulseN)
    else $error("carry did not return high after the clock rose");

endmodule

`default_nettype wire

// ===== bench/tb.sv
// Purpose : Self-checking bench joining the counter stage and its control end
// Assumes : 50 MHz clk, rst_n held low for two cycles
// Notes   : Inputs change by non-blocking assignment at rising edges, outputs read at falling edges
`timescale 1ns/100ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic               clk;
  logic               rst_n;
  logic               runEnable;
  logic               countDown;
  logic               loadRequest;
  logic [3:0]         loadValue;
  logic               loadBusy;
  logic [3:0]         countSeen;
  logic               terminalSeen;
  logic               carrySeen;
  logic               stepPulse;
  logic               wrapPulse;
  counter_pkg::mode_t modeNow;
  logic               got;
  logic [3:0]         held;
  int                 nMismatch;
  int                 nChecks;
  int                 cycles = 0;

  counter_link_if counter_link_if_i ();

  updown_counter_stage updown_counter_stage_i (.clk(clk), .rst_n(rst_n), .link(counter_link_if_i),
    .stepPulse(stepPulse), .wrapPulse(wrapPulse), .modeNow(modeNow));

  counter_control_end counter_control_end_i (.clk(clk), .rst_n(rst_n), .link(counter_link_if_i),
    .runEnable(runEnable), .countDown(countDown), .loadRequest(loadRequest), .loadValue(loadValue),
    .loadBusy(loadBusy), .countSeen(countSeen), .terminalSeen(terminalSeen), .carrySeen(carrySeen));

  counter_link_asserts counter_link_asserts_i (.clk(clk), .rst_n(rst_n),
    .countClock(counter_link_if_i.countClock), .presetStrobeN(counter_link_if_i.presetStrobeN),
    .presetInputs(counter_link_if_i.presetInputs), .countGateN(counter_link_if_i.countGateN),
    .dirDown(counter_link_if_i.dirDown), .countValue(counter_link_if_i.countValue),
    .terminalFlag(counter_link_if_i.terminalFlag), .stageCarryPulseN(counter_link_if_i.stageCarryPulseN));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nMismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    nChecks++;
    if (seen !== expected) begin
      nMismatch++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  // Waits for a step pulse (sel 0) or a carry pulse (sel 1), bounded
  task automatic wait_high(input int sel, output logic seenIt);
    seenIt = 1'b0;
    for (int i = 0; i < 40 && !seenIt; i++) begin
      @(negedge clk);
      seenIt = (sel == 0) ? (stepPulse === 1'b1) : (carrySeen === 1'b1);
    end
  endtask

  // Requests a preset and checks the outputs while the strobe is held
  task automatic load(input logic [3:0] v);
    @(posedge clk);
    loadRequest <= 1'b1;
    loadValue   <= v;
    @(posedge clk);
    loadRequest <= 1'b0;
    @(negedge clk);
    check({7'h00, loadBusy}, 8'h01);
    check({4'h0, counter_link_if_i.countValue}, {4'h0, v});
    check({6'h00, modeNow}, {6'h00, counter_pkg::MODE_PRESET});
    repeat (4) @(negedge clk);
    check({4'h0, countSeen}, {4'h0, v});
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    runEnable   = 1'b0;
    countDown   = 1'b0;
    loadRequest = 1'b0;
    loadValue   = 4'h0;
    nMismatch   = 0;
    nChecks     = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({4'h0, counter_link_if_i.countValue}, 8'h00);
    check({7'h00, counter_link_if_i.stageCarryPulseN}, 8'h01);
    // Preset to 14, then count up through the terminal value
    load(4'he);
    check({7'h00, counter_link_if_i.terminalFlag}, 8'h00);
    @(posedge clk);
    runEnable <= 1'b1;
    wait_high(0, got);
    check({7'h00, got}, 8'h01);
    check({4'h0, counter_link_if_i.countValue}, 8'h0f);
    check({7'h00, counter_link_if_i.terminalFlag}, 8'h01);
    check({6'h00, modeNow}, {6'h00, counter_pkg::MODE_UP});
    wait_high(1, got);
    check({7'h00, got}, 8'h01);
    wait_high(0, got);
    check({4'h0, counter_link_if_i.countValue}, 8'h00);
    check({7'h00, wrapPulse}, 8'h01);
    check({7'h00, counter_link_if_i.terminalFlag}, 8'h00);
    // Turn round at zero: flag rises on the direction change alone
    @(posedge clk);
    countDown <= 1'b1;
    repeat (10) @(negedge clk);
    check({7'h00, counter_link_if_i.terminalFlag}, 8'h01);
    check({6'h00, modeNow}, {6'h00, counter_pkg::MODE_DOWN});
    wait_high(0, got);
    check({4'h0, counter_link_if_i.countValue}, 8'h0f);
    check({7'h00, wrapPulse}, 8'h01);
    wait_high(0, got);
    check({4'h0, counter_link_if_i.countValue}, 8'h0e);
    check({7'h00, wrapPulse}, 8'h00);
    // Gate high: count holds over several counting clock periods
    @(posedge clk);
    runEnable <= 1'b0;
    repeat (12) @(negedge clk);
    held = counter_link_if_i.countValue;
    check({4'h0, held}, 8'h0e);
    repeat (40) @(negedge clk);
    check({4'h0, counter_link_if_i.countValue}, {4'h0, held});
    check({6'h00, modeNow}, {6'h00, counter_pkg::MODE_HOLD});
    check({7'h00, counter_link_if_i.stageCarryPulseN}, 8'h01);
    // Preset to zero while gated and counting down: flag ignores the gate
    load(4'h0);
    check({7'h00, counter_link_if_i.terminalFlag}, 8'h01);
    check({7'h00, terminalSeen}, 8'h01);
    check({7'h00, counter_link_if_i.stageCarryPulseN}, 8'h01);
    complete_run();
  end

endmodule

`default_nettype wire
